// ### hdl/wdog_pkg.sv
// constants and carrier types for the watchdog down counter
// assumes a single 40 MHz system clock and a 32.768 kHz tick pin
package wdog_pkg;
    // ------------------------------------------------------------
    // widths and reset values
    // ------------------------------------------------------------
    localparam int CNT_W = 32;
    localparam logic [31:0] LOAD_RST = 32'hffffffff;
    localparam logic [31:0] CNT_RST = 32'h00000000;
    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_HZ = 40000000;
    localparam int TICK_HZ = 32768;
    localparam int SYNC_STAGES = 2;
    // software controls gathered together
    typedef struct packed {
        logic enable;
        logic reload;
        logic clear_flag;
    } wdog_ctrl_t;
    // status toward the system
    typedef struct packed {
        logic irq;
        logic flag;
        logic sys_reset;
        logic wakeup;
    } wdog_stat_t;
endpackage : wdog_pkg

// ### hdl/tick_edge.sv
// synchroniser and rising edge detector for the slow tick clock pin
// assumes the pin is far slower than clk so every edge is seen
`timescale 1ns/1ps
module tick_edge (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // slow clock pin and its edge pulse
    input wire logic tick_pin,
    output logic tick_rise
);
    // ------------------------------------------------------------
    // two stage synchroniser, then edge detect on the second stage
    // ------------------------------------------------------------
    logic sync1_ff, sync2_ff, prev_ff;
    logic nxt_sync1, nxt_sync2, nxt_prev;
    // next values; first stage feeds only the second
    always_comb begin
        nxt_sync1 = tick_pin;
        nxt_sync2 = sync1_ff;
        nxt_prev = sync2_ff;
    end
    // registers only
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sync1_ff <= 1'b0;
            sync2_ff <= 1'b0;
            prev_ff <= 1'b0;
        end else begin
            sync1_ff <= nxt_sync1;
            sync2_ff <= nxt_sync2;
            prev_ff <= nxt_prev;
        end
    end
    assign tick_rise = sync2_ff & ~prev_ff;
endmodule : tick_edge

// ### hdl/watchdog_down_counter.sv
// watchdog down counter: counts 32.768 kHz ticks, interrupts at zero,
// reloads itself and resets the system on a second unserviced timeout
// assumes control inputs come from logic on clk; tick comes from a pin
//
// Function
// - 32-bit counter, one decrement per slow tick
// - at zero raise interrupt and status flag
// - at zero reload from load value automatically
// - timeout with flag still set resets system
// - interrupt stays pending until software clears flag
// - software reload restarts full interval anytime while enabled; ignored while disabled
// - interrupt works in standby, acts as wakeup
`timescale 1ns/1ps
module watchdog_down_counter #(
    parameter int CNT_W = wdog_pkg::CNT_W
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // slow watchdog clock pin, 32.768 kHz
    input wire logic tick_pin,
    // software side controls and load value
    input wire wdog_pkg::wdog_ctrl_t ctrl,
    input wire logic [CNT_W-1:0] watchdog_load_value,
    // system side status
    output wdog_pkg::wdog_stat_t stat,
    output logic [CNT_W-1:0] count
);
    // ------------------------------------------------------------
    // tick recovery
    // ------------------------------------------------------------
    logic tick_rise;
    tick_edge u_tick (
        .clk(clk),
        .rst(rst),
        .tick_pin(tick_pin),
        .tick_rise(tick_rise)
    );

    // ------------------------------------------------------------
    // counter and status state
    // ------------------------------------------------------------
    logic [CNT_W-1:0] cnt_ff, nxt_cnt;
    logic flag_ff, nxt_flag;
    logic rst_req_ff, nxt_rst_req;
    logic en_ff, nxt_en;
    logic timeout;

    // zero is reached on the tick that takes the counter from one, or on
    // every tick of a zero load value; a forced reload in the same cycle wins
    assign timeout = en_ff & ctrl.enable & ~ctrl.reload & tick_rise
        & (cnt_ff <= CNT_W'(1));

    // next values; reload and enable edge win over the decrement
    always_comb begin
        nxt_en = ctrl.enable;
        nxt_cnt = cnt_ff;
        nxt_flag = flag_ff;
        nxt_rst_req = rst_req_ff;
        if (!ctrl.enable) begin
            nxt_cnt = CNT_W'(wdog_pkg::CNT_RST);
            nxt_flag = flag_ff & ~ctrl.clear_flag;
        end else if (!en_ff || ctrl.reload) begin
            nxt_cnt = watchdog_load_value;
            nxt_flag = flag_ff & ~ctrl.clear_flag;
        end else if (tick_rise) begin
            if (cnt_ff == CNT_W'(1) || cnt_ff == '0) begin
                nxt_cnt = watchdog_load_value;
            end else begin
                nxt_cnt = cnt_ff - CNT_W'(1);
            end
            // set beats a clear arriving in the same cycle
            nxt_flag = timeout | (flag_ff & ~ctrl.clear_flag);
        end else begin
            nxt_flag = flag_ff & ~ctrl.clear_flag;
        end
        // second timeout while still pending; held until system reset
        // the request never drops by itself: the system must apply rst
        if (timeout && flag_ff) begin
            nxt_rst_req = 1'b1;
        end
    end

    // registers only
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_ff <= CNT_W'(wdog_pkg::CNT_RST);
            flag_ff <= 1'b0;
            rst_req_ff <= 1'b0;
            en_ff <= 1'b0;
        end else begin
            cnt_ff <= nxt_cnt;
            flag_ff <= nxt_flag;
            rst_req_ff <= nxt_rst_req;
            en_ff <= nxt_en;
        end
    end

    // ------------------------------------------------------------
    // outputs; wakeup mirrors the pending interrupt, needs no cpu
    // ------------------------------------------------------------
    always_comb begin
        stat.irq = flag_ff;
        stat.flag = flag_ff;
        stat.sys_reset = rst_req_ff;
        stat.wakeup = flag_ff;
    end
    assign count = cnt_ff;

    // ------------------------------------------------------------
    // checking aid: ticks seen since the last load, kept apart from
    // the counter so that a wrong decrement cannot hide itself; read
    // only by the assertions below, so synthesis trims it away
    // ------------------------------------------------------------
    logic [CNT_W-1:0] span_ff, nxt_span;
    logic [CNT_W-1:0] seen_ff, nxt_seen;
    logic load_evt;

    // any event that restarts the interval from the load value
    assign load_evt = ctrl.enable & (~en_ff | ctrl.reload | timeout);

    // next values; disabled clears both, a load restarts the count
    always_comb begin
        nxt_span = span_ff;
        nxt_seen = seen_ff;
        if (!ctrl.enable) begin
            nxt_span = '0;
            nxt_seen = '0;
        end else if (load_evt) begin
            nxt_span = watchdog_load_value;
            nxt_seen = '0;
        end else if (tick_rise) begin
            nxt_seen = seen_ff + CNT_W'(1);
        end
    end

    // registers only
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            span_ff <= '0;
            seen_ff <= '0;
        end else begin
            span_ff <= nxt_span;
            seen_ff <= nxt_seen;
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    a_idle_no_irq: assert property (@(posedge clk) disable iff (rst)
        (!ctrl.enable && !flag_ff) |=> !flag_ff && cnt_ff == '0)
        else $error("irq or count while disabled");
    a_tick_decr: assert property (@(posedge clk) disable iff (rst)
        (en_ff && ctrl.enable && !ctrl.reload && tick_rise && cnt_ff > CNT_W'(1))
        |=> cnt_ff == $past(cnt_ff) - CNT_W'(1))
        else $error("counter did not decrement on tick");
    a_hold_no_tick: assert property (@(posedge clk) disable iff (rst)
        (en_ff && ctrl.enable && !ctrl.reload && !tick_rise) |=> $stable(cnt_ff))
        else $error("counter moved without tick");
    a_zero_irq: assert property (@(posedge clk) disable iff (rst)
        timeout |=> stat.irq && flag_ff)
        else $error("no interrupt at zero");
    a_auto_reload: assert property (@(posedge clk) disable iff (rst)
        (timeout && !ctrl.reload) |=> cnt_ff == $past(watchdog_load_value))
        else $error("no reload at zero");
    a_second_reset: assert property (@(posedge clk) disable iff (rst)
        (timeout && flag_ff) |=> stat.sys_reset)
        else $error("no system reset on second timeout");
    a_flag_pending: assert property (@(posedge clk) disable iff (rst)
        (flag_ff && !ctrl.clear_flag) |=> flag_ff)
        else $error("flag dropped without clear");
    a_sw_reload: assert property (@(posedge clk) disable iff (rst)
        (ctrl.enable && ctrl.reload) |=> cnt_ff == $past(watchdog_load_value))
        else $error("forced reload missed");
    a_wake_irq: assert property (@(posedge clk) disable iff (rst)
        timeout |=> stat.wakeup)
        else $error("no wakeup at timeout");
    a_enable_load: assert property (@(posedge clk) disable iff (rst)
        $rose(ctrl.enable) |=> cnt_ff == $past(watchdog_load_value))
        else $error("enable did not load counter");

    // status path: set beats clear, clear works, reset request is sticky
    a_set_wins: assert property (@(posedge clk) disable iff (rst)
        (timeout && ctrl.clear_flag) |=> flag_ff)
        else $error("clear beat a new timeout");
    a_clear_flag: assert property (@(posedge clk) disable iff (rst)
        (ctrl.clear_flag && !timeout) |=> !flag_ff)
        else $error("flag not cleared");
    a_flag_cause: assert property (@(posedge clk) disable iff (rst)
        $rose(flag_ff) |-> $past(timeout))
        else $error("flag set without timeout");
    a_wake_follow: assert property (@(posedge clk) disable iff (rst)
        $rose(stat.wakeup) |-> $past(timeout))
        else $error("wakeup without timeout");
    a_reset_hold: assert property (@(posedge clk) disable iff (rst)
        stat.sys_reset |=> stat.sys_reset)
        else $error("system reset request dropped");
    a_reset_cause: assert property (@(posedge clk) disable iff (rst)
        $rose(stat.sys_reset) |-> $past(timeout) && $past(flag_ff))
        else $error("system reset without second timeout");

    // enable path: nothing moves and nothing fires while disabled
    a_off_no_reload: assert property (@(posedge clk) disable iff (rst)
        (!ctrl.enable && ctrl.reload) |=> cnt_ff == '0)
        else $error("reload acted while disabled");
    a_off_count_zero: assert property (@(posedge clk) disable iff (rst)
        !en_ff |-> cnt_ff == '0)
        else $error("count not zero while disabled");

    // counter path: one step per tick pulse, reload and interrupt at zero
    a_tick_pulse: assert property (@(posedge clk) disable iff (rst)
        tick_rise |=> !tick_rise)
        else $error("tick pulse longer than one cycle");
    a_zero_reload: assert property (@(posedge clk) disable iff (rst)
        (en_ff && ctrl.enable && !ctrl.reload && tick_rise && cnt_ff <= CNT_W'(1))
        |=> flag_ff && cnt_ff == $past(watchdog_load_value))
        else $error("no reload or flag at zero");
    // a timeout comes after exactly as many ticks as were loaded; a zero
    // load value times out on every tick and is left out
    a_period_ticks: assert property (@(posedge clk) disable iff (rst)
        (timeout && span_ff != '0) |-> seen_ff + CNT_W'(1) == span_ff)
        else $error("timeout after wrong number of ticks");
endmodule : watchdog_down_counter

// ### bench/watchdog_down_counter_bench.sv
// self-checking bench for the watchdog down counter
// assumes the design files and wdog_pkg are compiled first
`timescale 1ns/1ps
module watchdog_down_counter_bench;
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin errors++; \
    $display("CHECK FAILED t=%0t output mismatch", $time); end end
    // ----------------------------------------------------------------
    // signals and model state
    // ----------------------------------------------------------------
    logic clk, rst, tick_pin;
    wdog_pkg::wdog_ctrl_t ctrl;
    wdog_pkg::wdog_stat_t stat;
    logic [31:0] load, count;
    int errors, n_tests;
    int unsigned m_cnt;
    int m_flag, m_sysr, m_en;
    watchdog_down_counter DUT (.clk(clk), .rst(rst), .tick_pin(tick_pin), .ctrl(ctrl),
        .watchdog_load_value(load), .stat(stat), .count(count));
    // 40 MHz clock
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    // ----------------------------------------------------------------
    // tasks: drive on the rising edge, sample on the falling edge
    // ----------------------------------------------------------------
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask : cyc
    task automatic check();
        cyc(2);
        @(negedge clk);
        `CHK(count, m_cnt)
        `CHK(stat.flag, 1'(m_flag))
        `CHK(stat.irq, 1'(m_flag))
        `CHK(stat.wakeup, 1'(m_flag))
        `CHK(stat.sys_reset, 1'(m_sysr))
        @(posedge clk);
    endtask : check
    task automatic do_reset();
        rst <= 1'b1;
        ctrl <= '0;
        cyc(8);
        rst <= 1'b0;
        m_cnt = 0; m_flag = 0; m_sysr = 0; m_en = 0;
        check();
    endtask : do_reset
    // pin held 5 cycles each level, past the 3-cycle synchroniser path;
    // with_clr puts a clear in the very cycle the design takes the tick
    task automatic tick(input bit with_clr = 1'b0);
        tick_pin <= 1'b1;
        cyc(2);
        ctrl.clear_flag <= with_clr;
        cyc(1);
        ctrl.clear_flag <= 1'b0;
        cyc(2);
        tick_pin <= 1'b0;
        cyc(5);
        if (m_en != 0 && m_cnt <= 1) begin
            if (m_flag != 0) m_sysr = 1;
            m_flag = 1;
            m_cnt = load;
        end else begin
            if (m_en != 0) m_cnt--;
            if (with_clr) m_flag = 0;
        end
        check();
    endtask : tick
    task automatic en(input logic [31:0] v);
        load <= v;
        ctrl.enable <= 1'b1;
        cyc(1);
        m_en = 1; m_cnt = v;
        check();
    endtask : en
    task automatic rld(input logic [31:0] v);
        load <= v;
        ctrl.reload <= 1'b1;
        cyc(1);
        ctrl.reload <= 1'b0;
        if (m_en != 0) m_cnt = v;
        check();
    endtask : rld
    task automatic clr();
        ctrl.clear_flag <= 1'b1;
        cyc(1);
        ctrl.clear_flag <= 1'b0;
        m_flag = 0;
        check();
    endtask : clr
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : conclude
    // ----------------------------------------------------------------
    // tests
    // ----------------------------------------------------------------
    initial begin
        rst = 1'b1; tick_pin = 1'b0; ctrl = '0; load = 32'h0;
        errors = 0; n_tests = 0;
        void'($urandom(63580));
        do_reset();
        tick(); tick();
        $display("test idle done");
        en(32'h3);
        repeat (6) tick();
        $display("test double timeout done");
        do_reset();
        en(32'h2);
        tick(); tick(); clr(); tick(); tick(1'b1);
        tick(); rld(32'h5); tick();
        ctrl.enable <= 1'b0;
        m_en = 0; m_cnt = 0;
        check();
        rld(32'h7);
        en(32'h0); tick(); tick();
        $display("test service and reload done");
        do_reset();
        en(32'($urandom % 4 + 1));
        repeat (40) begin
            case ($urandom % 4)
                0: rld(32'($urandom % 6));
                1: clr();
                default: tick(1'($urandom % 2));
            endcase
        end
        $display("test random done");
        conclude();
    end
    // watchdog on the bench itself
    initial begin
        #2000000;
        errors++;
        conclude();
    end
endmodule : watchdog_down_counter_bench
